// *** snvcs_regs.vh ***
// Constants for the serial nonvolatile memory command slave.
`ifndef SNVCS_REGS_VH
`define SNVCS_REGS_VH
`define SNVCS_OP_SET_LATCH    8'h06
`define SNVCS_OP_CLEAR_LATCH  8'h04
`define SNVCS_OP_STATUS_READ  8'h05
`define SNVCS_OP_STATUS_WRITE 8'h01
`define SNVCS_OP_MEM_READ     8'h03
`define SNVCS_OP_MEM_WRITE    8'h02
`define SNVCS_OP_IDENT_READ   8'h9f
`define SNVCS_OP_SLEEP        8'hb9
`define SNVCS_ST_PROTECT_BIT  7
`define SNVCS_ST_LATCH_BIT    1
`define SNVCS_ST_WRITE_MASK   8'hfc
`define SNVCS_ST_RESET        8'h00
`define SNVCS_ADDR_BITS       15
`define SNVCS_FIFO_DEPTH      16
`endif

// *** snvcs_top.v ***
// Serial nonvolatile memory command slave with its write FIFO and array.
`timescale 1ns/10ps
`default_nettype none
`include "snvcs_regs.vh"

module snvcs_fifo #(
  parameter WIDTH = 23,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_i,     // System clock.
  input  wire             reset_i,   // Synchronous reset, active high.
  input  wire             in_valid_i, // Write side valid.
  output wire             in_ready_o, // Write side ready.
  input  wire [WIDTH-1:0] in_data_i,  // Write side data.
  output wire             out_valid_o, // Read side valid.
  input  wire             out_ready_i, // Read side ready.
  output wire [WIDTH-1:0] out_data_o   // Read side data.
);
  // Storage array and pointers, the pointers one bit wider than the index.
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            full_w;
  wire            empty_w;
  wire [AW:0]     ptr_one_w = {{AW{1'b0}}, 1'b1};

  // Extra pointer bit tells full from empty; DEPTH must equal 2**AW, as pointers wrap by overflow.
  assign empty_w     = (wr_q == rd_q);
  assign full_w      = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign in_ready_o  = !full_w;
  assign out_valid_o = !empty_w;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];

  // Pointer and storage update.
  // Storage has no reset; only the pointers decide which words are valid.
  always @(posedge clk_i) begin
    if (reset_i) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid_i && !full_w) begin
        mem_q[wr_q[AW-1:0]] <= in_data_i;
        wr_q <= wr_q + ptr_one_w;
      end
      if (out_ready_i && !empty_w) begin
        rd_q <= rd_q + ptr_one_w;
      end
    end
  end
endmodule

module snvcs_top #(
  parameter ABITS = `SNVCS_ADDR_BITS,
  parameter DEPTH = `SNVCS_FIFO_DEPTH
) (
  input  wire       clk_i,       // System clock, 250 MHz.
  input  wire       reset_i,     // Synchronous reset, active high.
  input  wire       sel_n_i,     // Chip select pin, active low.
  input  wire       sck_i,       // Serial clock pin.
  input  wire       sdi_i,       // Serial data in pin.
  input  wire       wp_n_i,      // Write-protect pin, active low.
  output reg        sdo_o,       // Serial data out.
  output reg        sdo_oe_o,    // Serial data out enable, high while driven.
  output wire [7:0] status_o,    // Status register view.
  output wire       write_busy_o // Write FIFO still holds bytes.
);
  // Command states. Every frame starts in opcode reception; address collection hands over to the
  // command remembered in cmd_q, and finished or ignored commands park in the idle state.
  localparam ST_OPCODE = 3'd0;
  localparam ST_ADDR   = 3'd1;
  localparam ST_SREAD  = 3'd2;
  localparam ST_SWRITE = 3'd3;
  localparam ST_MREAD  = 3'd4;
  localparam ST_MWRITE = 3'd5;
  localparam ST_IDLE   = 3'd6;

  // The four pins share one two-stage synchroniser pattern; only the second stage leaves the loop.
  localparam NPINS = 4;
  wire [NPINS-1:0] pin_raw_w = {wp_n_i, sdi_i, sck_i, sel_n_i};
  wire [NPINS-1:0] pin_sync_w;
  genvar           gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_sync
      reg [1:0] stage_q;
      // Stage zero may go metastable, so nothing but stage one reads it.
      always @(posedge clk_i) begin
        stage_q <= {stage_q[0], pin_raw_w[gi]};
      end
      assign pin_sync_w[gi] = stage_q[1];
    end
  endgenerate

  wire sel_n_w = pin_sync_w[0];
  wire sck_w   = pin_sync_w[1];
  wire sdi_w   = pin_sync_w[2];
  wire wp_n_w  = pin_sync_w[3];

  // One more flop holds the previous clock level; it follows the pin in reset as well, so the
  // idle level of either clock mode never looks like an edge after reset.
  reg sck_prev_q;
  always @(posedge clk_i) begin
    sck_prev_q <= sck_w;
  end

  // Edges count only while selected. The clock is sampled, so its half period must span at
  // least two system clocks for every edge to be seen once.
  wire rise_w  = !sel_n_w && sck_w && !sck_prev_q;
  wire fall_w  = !sel_n_w && !sck_w && sck_prev_q;

  // Engine registers. bitcnt_q counts bits within the current byte and wraps every eight,
  // addrcnt_q counts the sixteen address bits, and the array itself keeps its contents
  // through reset, as a nonvolatile store would.
  reg [2:0]       state_q;
  reg [2:0]       cmd_q;
  reg [2:0]       bitcnt_q;
  reg [4:0]       addrcnt_q;
  reg [7:0]       shift_q;
  reg [7:0]       out_q;
  reg [15:0]      addr_sh_q;
  reg [ABITS-1:0] addr_q;
  reg [7:0]       status_q;
  reg             sw_pending_q;
  reg             sel_prev_q;
  reg [7:0]       mem_q [0:(1<<ABITS)-1];
  wire [7:0]      rx_byte_w = {shift_q[6:0], sdi_w};
  // Next array address; the carry out of the top bit is dropped, and that drop is the wrap.
  wire [ABITS-1:0] addr_next_w = addr_q + {{(ABITS-1){1'b0}}, 1'b1};

  // Block-protect decode, used for every array write. The protected region always ends at the
  // top of the array, so only the upper address bits take part.
  function prot_hit;
    input [1:0]       bp;
    input [ABITS-1:0] a;
    begin
      case (bp)
        2'b00:   prot_hit = 1'b0;
        2'b01:   prot_hit = (a[ABITS-1:ABITS-2] == 2'b11);
        2'b10:   prot_hit = a[ABITS-1];
        default: prot_hit = 1'b1;
      endcase
    end
  endfunction

  // Status writes need the latch, and the pin unless protect enable is off. The pin is read
  // at the last data rise, so a master that moves it inside the frame gets either outcome.
  wire sw_allowed_w = status_q[`SNVCS_ST_LATCH_BIT] &&
                      (!status_q[`SNVCS_ST_PROTECT_BIT] || wp_n_w);

  // Write bytes queue in the FIFO so the array port is decoupled from the link.
  // A byte is pushed only while the queue has room; at link rates the queue drains far
  // faster than bytes arrive, so that refusal cannot happen in practice.
  wire             fifo_in_ready_w;
  wire             fifo_out_valid_w;
  wire [ABITS+7:0] fifo_out_data_w;
  reg              fifo_push_q;
  reg [ABITS+7:0]  fifo_data_q;
  snvcs_fifo #(.WIDTH(ABITS+8), .DEPTH(DEPTH), .AW(4)) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (fifo_push_q),
    .in_ready_o  (fifo_in_ready_w),
    .in_data_i   (fifo_data_q),
    .out_valid_o (fifo_out_valid_w),
    .out_ready_i (1'b1),
    .out_data_o  (fifo_out_data_w)
  );
  // Busy stays high one cycle per queued byte, since the array drains the queue every cycle.
  assign write_busy_o = fifo_out_valid_w;
  assign status_o     = status_q;

  // Array write port drains the FIFO one byte per cycle.
  // Contents have no reset, as befits a store that keeps its data without power.
  always @(posedge clk_i) begin
    if (fifo_out_valid_w) begin
      mem_q[fifo_out_data_w[ABITS+7:8]] <= fifo_out_data_w[7:0];
    end
  end

  // Serial command engine; all state returns to opcode reception while deselected.
  // Bits are taken on detected rises and output bits launched on detected falls, so the
  // reply reaches the pin two to three system clocks after the serial clock edge; the
  // master samples on its next rise, half a serial period later.
  always @(posedge clk_i) begin
    fifo_push_q <= 1'b0;
    sel_prev_q  <= sel_n_w;
    if (reset_i) begin
      state_q      <= ST_OPCODE;
      cmd_q        <= 3'd0;
      bitcnt_q     <= 3'd0;
      addrcnt_q    <= 5'd0;
      shift_q      <= 8'h00;
      out_q        <= 8'h00;
      addr_sh_q    <= 16'h0000;
      addr_q       <= {ABITS{1'b0}};
      status_q     <= `SNVCS_ST_RESET;
      sw_pending_q <= 1'b0;
      sdo_o        <= 1'b0;
      sdo_oe_o     <= 1'b0;
      fifo_data_q  <= {(ABITS+8){1'b0}};
    end else if (sel_n_w) begin
      state_q   <= ST_OPCODE;
      bitcnt_q  <= 3'd0;
      addrcnt_q <= 5'd0;
      sdo_oe_o  <= 1'b0;
      // The latch drops on the select edge closing a status write.
      // The previous select level marks the first deselected cycle, so this fires once per frame.
      if (!sel_prev_q && sw_pending_q) begin
        status_q[`SNVCS_ST_LATCH_BIT] <= 1'b0;
      end
      sw_pending_q <= 1'b0;
    end else begin
      if (rise_w) begin
        shift_q  <= rx_byte_w;
        bitcnt_q <= bitcnt_q + 3'd1;
        case (state_q)
          // The eighth rise completes the opcode; a frame cut earlier never gets this far.
          ST_OPCODE: begin
            if (bitcnt_q == 3'd7) begin
              case (rx_byte_w)
                // Latch commands act on the eighth rise, without waiting for deselect.
                `SNVCS_OP_SET_LATCH: begin
                  status_q[`SNVCS_ST_LATCH_BIT] <= 1'b1;
                  state_q <= ST_IDLE;
                end
                `SNVCS_OP_CLEAR_LATCH: begin
                  status_q[`SNVCS_ST_LATCH_BIT] <= 1'b0;
                  state_q <= ST_IDLE;
                end
                // The first status copy is taken now, so the first fall can send bit seven.
                `SNVCS_OP_STATUS_READ: begin
                  out_q   <= status_q;
                  state_q <= ST_SREAD;
                end
                `SNVCS_OP_STATUS_WRITE: begin
                  state_q      <= ST_SWRITE;
                  sw_pending_q <= 1'b1;
                end
                // Both memory commands collect an address first and remember which one follows.
                `SNVCS_OP_MEM_READ: begin
                  cmd_q   <= ST_MREAD;
                  state_q <= ST_ADDR;
                end
                `SNVCS_OP_MEM_WRITE: begin
                  cmd_q   <= ST_MWRITE;
                  state_q <= ST_ADDR;
                end
                // Identity read and sleep belong to neighbouring logic.
                default: state_q <= ST_IDLE;
              endcase
            end
          end
          // Sixteen address bits; the first byte is fetched on the last rise so that the
          // very next fall can already send its top bit.
          ST_ADDR: begin
            addr_sh_q <= {addr_sh_q[14:0], sdi_w};
            addrcnt_q <= addrcnt_q + 5'd1;
            if (addrcnt_q == 5'd15) begin
              addr_q  <= {addr_sh_q[ABITS-2:0], sdi_w};
              state_q <= cmd_q;
              out_q   <= mem_q[{addr_sh_q[ABITS-2:0], sdi_w}];
            end
          end
          // Latch and bit zero keep their own values; a refused write still ends the frame's use.
          ST_SWRITE: begin
            if (bitcnt_q == 3'd7) begin
              if (sw_allowed_w) begin
                status_q <= (rx_byte_w & `SNVCS_ST_WRITE_MASK) |
                            (status_q & 8'h02);
              end
              state_q <= ST_IDLE;
            end
          end
          // Each complete byte that the latch and block protect allow is queued with its address; a byte cut by deselect is dropped.
          ST_MWRITE: begin
            if (bitcnt_q == 3'd7) begin
              // Refused bytes still advance the address, as a protected cell would.
              if (status_q[`SNVCS_ST_LATCH_BIT] && !prot_hit(status_q[3:2], addr_q)) begin
                fifo_push_q <= fifo_in_ready_w; // Overflow only at far above link rates.
                fifo_data_q <= {addr_q, rx_byte_w};
              end
              addr_q <= addr_next_w;
            end
          end
          // Every eighth rise moves to the next byte, wrapping at the top of the array.
          ST_MREAD: begin
            if (bitcnt_q == 3'd7) begin
              addr_q <= addr_next_w;
              out_q  <= mem_q[addr_next_w];
            end
          end
          // The status is reloaded after each byte, so a long read shows any change from the next byte on.
          ST_SREAD: begin
            if (bitcnt_q == 3'd7) begin
              out_q <= status_q;
            end
          end
          // Finished, refused and neighbouring commands wait here for deselect.
          ST_IDLE: begin
            state_q <= ST_IDLE;
          end
          default: state_q <= ST_OPCODE;
        endcase
      end
      // Output changes only on falling serial edges; input is ignored meanwhile.
      // The enable rises with the first bit and drops only at deselect, releasing the pin.
      if (fall_w && (state_q == ST_SREAD || state_q == ST_MREAD)) begin
        sdo_oe_o <= 1'b1;
        sdo_o    <= out_q[3'd7 - bitcnt_q];
      end
    end
  end
endmodule
`default_nettype wire

// *** snvcs_assertions.sv ***
// Pin-level checks for the serial memory command slave.
`timescale 1ns/10ps
`default_nettype none
module snvcs_assertions (
  input wire logic       clk_i,       // System clock.
  input wire logic       reset_i,     // Synchronous reset.
  input wire logic       sel_n_i,     // Chip select, active low.
  input wire logic       sck_i,       // Serial clock.
  input wire logic       sdi_i,       // Serial data in.
  input wire logic       wp_n_i,      // Write-protect pin, active low.
  input wire logic       sdo_o,       // Serial data out.
  input wire logic       sdo_oe_o,    // Data out enable.
  input wire logic [7:0] status_o,    // Status view.
  input wire logic       write_busy_o // Write queue busy.
);
  // Pins pass a two-stage synchroniser, so every window allows three to four cycles of lag.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence deselected_s;
    sel_n_i [*6];
  endsequence
  sequence locked_s;
    (status_o[7] && !wp_n_i) [*4];
  endsequence
  out_released_a: assert property (deselected_s |-> !sdo_oe_o)
    else $error("data out driven while deselected");
  bit_zero_a: assert property (status_o[0] == 1'b0)
    else $error("status bit zero set");
  latch_set_a: assert property ($rose(status_o[1]) |-> !$past(sel_n_i, 6))
    else $error("latch set without selection");
  status_idle_a: assert property (sel_n_i [*8] |=> $stable(status_o))
    else $error("status moved while deselected");
  sdo_on_fall_a: assert property (($changed(sdo_o) && sdo_oe_o && $past(sdo_oe_o)) |-> !$past(sck_i, 3))
    else $error("data out changed away from a falling clock");
  oe_selected_a: assert property (sdo_oe_o |-> !$past(sel_n_i, 5))
    else $error("data out enabled without selection");
  busy_drains_a: assert property ($rose(write_busy_o) |-> ##[1:40] !write_busy_o)
    else $error("write queue did not drain");
  status_cause_a: assert property ($changed(status_o) |-> ($past(sck_i, 3) || $past(sel_n_i, 3)))
    else $error("status changed without a clock rise or deselect");
  protect_lock_a: assert property (locked_s |=> $stable(status_o[7:2]))
    else $error("protected status bits changed");
endmodule
bind snvcs_top snvcs_assertions chk (.clk_i(clk_i), .reset_i(reset_i), .sel_n_i(sel_n_i), .sck_i(sck_i),
  .sdi_i(sdi_i), .wp_n_i(wp_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .status_o(status_o),
  .write_busy_o(write_busy_o));
`default_nettype wire

// *** snvcs_spi_master.sv ***
// Serial bus master model that frames commands for the memory slave.
`timescale 1ns/10ps
`default_nettype none
module snvcs_spi_master (
  input  wire logic clk_i,    // System clock used for pacing.
  input  wire logic sdo_i,    // Slave data out.
  input  wire logic sdo_oe_i, // Slave data out enable.
  output var  logic sel_n_o,  // Chip select, active low.
  output var  logic sck_o,    // Serial clock.
  output var  logic sdi_o     // Serial data to the slave.
);
  localparam int HALF = 20;
  logic cpol = 1'b0;
  // Deselected and idle at time zero.
  initial begin
    sel_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // The idle level is set while deselected, so a mode change never looks like a bit.
  task automatic open_f();
    sck_o <= cpol;
    wait_c(HALF);
    sel_n_o <= 1'b0;
    wait_c(HALF);
  endtask
  task automatic close_f();
    sck_o <= cpol;
    wait_c(HALF);
    sel_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    wait_c(HALF);
  endtask
  // Bits go MSB first; a released data line reads inverted so it can never pass as data.
  task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      sck_o <= 1'b0;
      sdi_o <= tx[i];
      wait_c(HALF);
      sck_o <= 1'b1;
      rx[i] = sdo_oe_i ? sdo_i : ~sdo_i;
      wait_c(HALF);
    end
  endtask
endmodule
`default_nettype wire

// *** test_spi_nvram_command_slave.sv ***
// Self-checking bench for the serial memory command slave.
`timescale 1ns/10ps
`default_nettype none
`include "snvcs_regs.vh"
module test_spi_nvram_command_slave;
  logic       clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       wp_n_i = 1'b1;
  logic       sel_n, sck, sdi, sdo, sdo_oe, busy;
  logic [7:0] status;
  int         bad_count = 0;
  int         compares = 0;
  int         busy_n = 0;
  // Counts busy cycles of the write queue; each accepted byte keeps it busy for one cycle.
  always @(posedge clk_i) begin
    if (busy === 1'b1) busy_n <= busy_n + 1;
  end
  // 250 MHz system clock.
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  snvcs_top dut (.clk_i(clk_i), .reset_i(reset_i), .sel_n_i(sel_n), .sck_i(sck), .sdi_i(sdi), .wp_n_i(wp_n_i),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .status_o(status), .write_busy_o(busy));
  snvcs_spi_master m (.clk_i(clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .sel_n_o(sel_n), .sck_o(sck), .sdi_o(sdi));
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input int nb);
    logic [7:0] r;
    m.open_f();
    m.shift(op, nb, r);
    m.close_f();
  endtask
  // The latch set always comes first, as a well-behaved master must do.
  task automatic st_wr(input logic [7:0] v);
    logic [7:0] r;
    cmd(`SNVCS_OP_SET_LATCH, 8);
    m.open_f();
    m.shift(`SNVCS_OP_STATUS_WRITE, 8, r);
    m.shift(v, 8, r);
    m.close_f();
  endtask
  // Two status bytes in one frame, then the register view once deselected.
  task automatic st_chk(input logic [7:0] exp);
    logic [7:0] r;
    m.open_f();
    m.shift(`SNVCS_OP_STATUS_READ, 8, r);
    m.shift(8'h5a, 8, r);
    chk8("status byte", exp, r);
    m.shift(8'ha5, 8, r);
    chk8("status repeat", exp, r);
    m.close_f();
    chk8("status view", exp, status);
  endtask
  task automatic mem(input logic wr, input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] r;
    m.open_f();
    m.shift(wr ? `SNVCS_OP_MEM_WRITE : `SNVCS_OP_MEM_READ, 8, r);
    m.shift(a[15:8], 8, r);
    m.shift(a[7:0], 8, r);
    m.shift(d0, 8, r);
    if (!wr) chk8("read byte", d0, r);
    m.shift(d1, 8, r);
    if (!wr) chk8("next byte", d1, r);
    m.close_f();
  endtask
  // Main sequence; every frame is framed by the master model.
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    m.wait_c(4);
    st_chk(`SNVCS_ST_RESET);
    cmd(`SNVCS_OP_SET_LATCH, 8);
    st_chk(8'h02);
    cmd(`SNVCS_OP_CLEAR_LATCH, 8);
    st_chk(8'h00);
    cmd(`SNVCS_OP_SET_LATCH, 7);
    st_chk(8'h00);
    cmd(`SNVCS_OP_IDENT_READ, 8);
    st_chk(8'h00);
    $display("test latch done");
    cmd(`SNVCS_OP_SET_LATCH, 8);
    mem(1'b1, 16'hffff, 8'ha1, 8'hb2);
    chk8("queued bytes", 8'h02, busy_n[7:0]);
    mem(1'b0, 16'h7fff, 8'ha1, 8'hb2);
    cmd(`SNVCS_OP_SET_LATCH, 8);
    mem(1'b1, 16'h5fff, 8'hc1, 8'hc2);
    chk8("queued bytes", 8'h04, busy_n[7:0]);
    st_wr(8'h04);
    st_chk(8'h04);
    cmd(`SNVCS_OP_SET_LATCH, 8);
    mem(1'b1, 16'h5fff, 8'h11, 8'h22);
    chk8("queued bytes", 8'h05, busy_n[7:0]);
    mem(1'b0, 16'h5fff, 8'h11, 8'hc2);
    cmd(`SNVCS_OP_CLEAR_LATCH, 8);
    mem(1'b1, 16'h5fff, 8'h99, 8'h99);
    chk8("queued bytes", 8'h05, busy_n[7:0]);
    mem(1'b0, 16'h5fff, 8'h11, 8'hc2);
    $display("test memory done");
    st_wr(8'hff);
    st_chk(8'hfc);
    wp_n_i <= 1'b0;
    st_wr(8'h00);
    st_chk(8'hfc);
    wp_n_i <= 1'b1;
    st_wr(8'h03);
    m.cpol = 1'b1;
    st_chk(8'h00);
    $display("test status done");
    wrap_up();
  end
  // Watchdog at about twice the expected run of some 30000 cycles.
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
